// ==== bench/tfl_env.sv ====
/* surrounding logic model: element clock levels.
   assumes data is set before tick is called. */
module tfl_env (
	input logic sys_clk,
	output logic [6:0] eclk
);
	timeunit 1ns;
	timeprecision 1ps;
	initial eclk = 7'h00;
	// two cycles per level so each edge is seen; data may move
	// only once the high level is sampled, clear of set-up and
	// hold
	task automatic tick(input logic [6:0] m);
		@(posedge sys_clk);
		eclk <= m;
		repeat (2) @(posedge sys_clk);
		eclk <= 7'h00;
		repeat (2) @(posedge sys_clk);
	endtask
endmodule

// ==== bench/tfl_family_tb.sv ====
/* bench for the storage family.
   assumes tfl_env clocks the elements. */
module tfl_family_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, reset = 1'b1, look = 1'b0;
	logic [2:0] sj = 3'h0, sk = 3'h0;
	logic [1:0] cj = 2'h0, ck = 2'h0, pj = 2'h0, pk = 2'h0, dd = 2'h0;
	logic [1:0] stb = 2'h0;
	logic [3:0] ld = 4'h0;
	logic [4:0] setn = 5'h1f;
	logic [6:0] clrn = 7'h7f;
	logic [31:0] rs = 32'h262d;
	logic [10:0] mq = 11'h000;
	logic [10:0] expq[$];
	logic [10:0] mon_e;
	int num_errors = 0, n_tests = 0;
	wire [6:0] eclk;
	wire sq;
	wire [1:0] cq, pq, dq;
	wire [3:0] lq;
	wire [10:0] obs = {sq, cq, pq, dq, lq};
	wire sqn;
	wire [1:0] cqn, pqn, dqn;
	wire [3:0] lqn;
	wire [10:0] obsn = {sqn, cqn, pqn, dqn, lqn};
	always #2 sys_clk = ~sys_clk;
	// one sink per output, nothing tied together
	tfl_family u_dut (.sys_clk(sys_clk), .reset(reset),
		.sjk_clk(eclk[0]), .sjk_j(sj), .sjk_k(sk), .sjk_set_n(setn[0]),
		.sjk_clr_n(clrn[0]), .sjk_q(sq), .sjk_qn(sqn), .cjk_clk(eclk[2:1]),
		.cjk_j(cj), .cjk_k(ck), .cjk_clr_n(clrn[2:1]), .cjk_q(cq),
		.cjk_qn(cqn), .pjk_clk(eclk[4:3]), .pjk_j(pj), .pjk_k(pk),
		.pjk_set_n(setn[2:1]), .pjk_clr_n(clrn[4:3]), .pjk_q(pq),
		.pjk_qn(pqn), .dd_clk(eclk[6:5]), .dd_d(dd), .dd_set_n(setn[4:3]),
		.dd_clr_n(clrn[6:5]), .dd_q(dq), .dd_qn(dqn), .lat_strobe(stb),
		.lat_d(ld), .lat_q_reg(lq), .lat_qn_reg(lqn));
	tfl_env u_env (.sys_clk(sys_clk), .eclk(eclk));
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	// hold, clear, set or toggle
	function automatic logic jk(input logic q, j, k);
		return (j & k) ? !q : (j ? 1'b1 : (k ? 1'b0 : q));
	endfunction
	task automatic cmp(input logic [10:0] e, g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic note(input logic [10:0] e);
		expq.push_back(e);
		look <= 1'b1;
		@(posedge sys_clk);
		look <= 1'b0;
	endtask
	task automatic give_verdict();
		if (num_errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// outputs settle on the rising edge; read half a cycle on
	always @(negedge sys_clk) begin
		if (look && expq.size() > 0) begin
			mon_e = expq.pop_front();
			cmp(mon_e, obs);
			cmp(~mon_e, obsn);
		end
	end
	initial begin
		logic [31:0] r;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		// random data, strobes and clock mask per burst
		for (int i = 0; i < 40; i++) begin
			@(posedge sys_clk);
			r = rnd();
			{pk, pj, ck, cj, sk, sj} <= r[13:0];
			{ld, stb, dd} <= r[21:14];
			if (r[22]) mq[10] = jk(mq[10], &r[2:0], &r[5:3]);
			for (int h = 0; h < 2; h++) begin
				if (r[23+h]) mq[8+h] = jk(mq[8+h], r[6+h], r[8+h]);
				if (r[25+h]) mq[6+h] = jk(mq[6+h], r[10+h], r[12+h]);
				if (r[27+h]) mq[4+h] = r[14+h];
				if (r[16+h]) mq[2*h +: 2] = r[18+2*h +: 2];
			end
			fork
				u_env.tick(r[28:22]);
				begin
					// j, k and d move once high is seen: no effect
					repeat (2) @(posedge sys_clk);
					r = rnd();
					{pk, pj, ck, cj, sk, sj} <= r[13:0];
					dd <= r[15:14];
				end
			join
			note(mq);
		end
		// direct set with clocks idle
		@(posedge sys_clk);
		setn <= 5'h00;
		@(posedge sys_clk);
		setn <= 5'h1f;
		mq[10:4] = {1'b1, mq[9:8], 4'hf};
		note(mq);
		// clear in the clock-high phase must survive the fall
		fork
			u_env.tick(7'h7f);
			begin
				repeat (2) @(posedge sys_clk);
				clrn <= 7'h00;
				@(posedge sys_clk);
				clrn <= 7'h7f;
			end
		join
		mq[10:4] = 7'h00;
		note(mq);
		for (int i = 0; i < 4 && expq.size() > 0; i++) @(negedge sys_clk);
		if (expq.size() > 0) num_errors++;
		give_verdict();
	end
endmodule

// ==== bench/tfl_props.sv ====
/* checker for the storage family top.
   assumes sys_clk with synchronous reset. */
module tfl_props (
	input logic sys_clk,
	input logic reset,
	input logic sjk_clk,
	input logic sjk_set_n,
	input logic sjk_clr_n,
	input logic sjk_q,
	input logic sjk_qn,
	input logic [1:0] cjk_clr_n,
	input logic [1:0] cjk_q,
	input logic [1:0] dd_clk,
	input logic [1:0] dd_d,
	input logic [1:0] dd_set_n,
	input logic [1:0] dd_clr_n,
	input logic [1:0] dd_q,
	input logic [1:0] lat_strobe,
	input logic [3:0] lat_d,
	input logic [3:0] lat_q_reg
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// output moves only after a fall or a direct input
	jk_edge_only_a: assert property ($changed(sjk_q) |->
		$past(sjk_clk, 2) && !$past(sjk_clk) || !$past(sjk_set_n) ||
		!$past(sjk_clr_n) || $past(reset)) else $error("jk moved");
	jk_clear_a: assert property (!sjk_clr_n |=> !sjk_q)
		else $error("jk clear");
	dual_clear_a: assert property (!cjk_clr_n[1] |=> !cjk_q[1])
		else $error("dual clear");
	d_load_a: assert property (dd_clk[0] && !$past(dd_clk[0]) &&
		!$past(reset) && dd_set_n[0] && dd_clr_n[0] |=>
		dd_q[0] == $past(dd_d[0], 2)) else $error("d load");
	d_set_a: assert property (!dd_set_n[1] && dd_clr_n[1] |=> dd_q[1])
		else $error("d set");
	latch_follow_a: assert property (lat_strobe[0] |=>
		lat_q_reg[1:0] == $past(lat_d[1:0])) else $error("follow");
	latch_hold_a: assert property (!lat_strobe[1] |=>
		$stable(lat_q_reg[3:2])) else $error("hold");
	out_pair_a: assert property (sjk_qn != sjk_q)
		else $error("pair");
endmodule
bind tfl_family tfl_props u_props (.*);

// ==== hw/tfl_d_cell.v ====
/*
 * one positive-edge d storage cell with steering stage.
 * assumes the element clock is a synchronous input.
 */
`include "tfl_defines.vh"

module tfl_d_cell (
	input wire sys_clk,
	input wire reset,
	input wire clk_in,
	input wire d_in,
	input wire set_n,
	input wire clr_n,
	output reg q_reg,
	output reg qn_reg
);

	reg clk_prev_reg;
	reg steer_reg;
	reg q_next;

	// storage next value; direct inputs override the clock
	always @* begin
		q_next = q_reg;
		if (!clr_n) begin
			q_next = 1'h0;
		end else if (!set_n) begin
			q_next = 1'h1;
		end else if (!clk_prev_reg && clk_in) begin
			q_next = steer_reg;
		end
	end

	// steering stage tracks d only in the low phase
	always @(posedge sys_clk) begin
		if (reset) begin
			clk_prev_reg <= `TFL_RST_HIST;
			steer_reg <= `TFL_RST_Q;
			q_reg <= `TFL_RST_Q;
			qn_reg <= `TFL_RST_QN;
		end else begin
			clk_prev_reg <= clk_in;
			if (!clk_in) begin
				steer_reg <= d_in;
			end
			q_reg <= q_next;
			qn_reg <= ~q_next;
		end
	end

endmodule

// ==== hw/tfl_defines.vh ====
/*
 * shared constants for the storage element family.
 * assumes plain verilog-2005 and inclusion by bare name.
 */
`ifndef TFL_DEFINES_VH
`define TFL_DEFINES_VH

// bit position of each half inside two-bit element buses
`define TFL_HALF_A 0
`define TFL_HALF_B 1
// number of latches in the quad block
`define TFL_LATCH_N 4
// reset value of stored state and output pairs
`define TFL_RST_Q 1'h0
`define TFL_RST_QN 1'h1
// edge-detect history after reset matches the idle clock level
`define TFL_RST_HIST 1'h0
// latches sharing one strobe
`define TFL_PAIR_SIZE 2

`endif

// ==== hw/tfl_family.v ====
/*
 * storage element family: single j-k with anded inputs, dual
 * j-k with clear only, dual j-k with set and clear, dual d,
 * and quad latch with strobes shared per pair.
 * assumes every element clock, strobe, data and direct input
 * is synchronous to sys_clk and held at least two cycles per
 * level, so each edge is seen; direct inputs are active low.
 */
`include "tfl_defines.vh"

module tfl_family (
	input wire sys_clk,
	input wire reset,
	// single j-k element
	input wire sjk_clk,
	input wire [2:0] sjk_j,
	input wire [2:0] sjk_k,
	input wire sjk_set_n,
	input wire sjk_clr_n,
	output wire sjk_q,
	output wire sjk_qn,
	// first dual j-k, clear only
	input wire [1:0] cjk_clk,
	input wire [1:0] cjk_j,
	input wire [1:0] cjk_k,
	input wire [1:0] cjk_clr_n,
	output wire [1:0] cjk_q,
	output wire [1:0] cjk_qn,
	// second dual j-k, set and clear
	input wire [1:0] pjk_clk,
	input wire [1:0] pjk_j,
	input wire [1:0] pjk_k,
	input wire [1:0] pjk_set_n,
	input wire [1:0] pjk_clr_n,
	output wire [1:0] pjk_q,
	output wire [1:0] pjk_qn,
	// dual d element
	input wire [1:0] dd_clk,
	input wire [1:0] dd_d,
	input wire [1:0] dd_set_n,
	input wire [1:0] dd_clr_n,
	output wire [1:0] dd_q,
	output wire [1:0] dd_qn,
	// quad latch; strobe 0 gates latches 0-1, strobe 1 gates 2-3
	input wire [1:0] lat_strobe,
	input wire [3:0] lat_d,
	output reg [3:0] lat_q_reg,
	output reg [3:0] lat_qn_reg
);

	wire sjk_j_all;
	wire sjk_k_all;

	// and-input groups ahead of the single cell
	assign sjk_j_all = &sjk_j;
	assign sjk_k_all = &sjk_k;

	// single cell; its outputs are cell flip-flops
	tfl_jk_cell u_sjk (
		.sys_clk(sys_clk),
		.reset(reset),
		.clk_in(sjk_clk),
		.j_in(sjk_j_all),
		.k_in(sjk_k_all),
		.set_n(sjk_set_n),
		.clr_n(sjk_clr_n),
		.q_reg(sjk_q),
		.qn_reg(sjk_qn)
	);

	// dual elements, one cell per half
	genvar h;
	generate
		for (h = `TFL_HALF_A; h <= `TFL_HALF_B; h = h + 1) begin : g_half
			// clear-only halves: set tied inactive
			tfl_jk_cell u_cjk (
				.sys_clk(sys_clk),
				.reset(reset),
				.clk_in(cjk_clk[h]),
				.j_in(cjk_j[h]),
				.k_in(cjk_k[h]),
				.set_n(1'h1),
				.clr_n(cjk_clr_n[h]),
				.q_reg(cjk_q[h]),
				.qn_reg(cjk_qn[h])
			);
			// both direct inputs per half
			tfl_jk_cell u_pjk (
				.sys_clk(sys_clk),
				.reset(reset),
				.clk_in(pjk_clk[h]),
				.j_in(pjk_j[h]),
				.k_in(pjk_k[h]),
				.set_n(pjk_set_n[h]),
				.clr_n(pjk_clr_n[h]),
				.q_reg(pjk_q[h]),
				.qn_reg(pjk_qn[h])
			);
			// d halves take d from the last low-phase cycle before the edge
			tfl_d_cell u_dd (
				.sys_clk(sys_clk),
				.reset(reset),
				.clk_in(dd_clk[h]),
				.d_in(dd_d[h]),
				.set_n(dd_set_n[h]),
				.clr_n(dd_clr_n[h]),
				.q_reg(dd_q[h]),
				.qn_reg(dd_qn[h])
			);
		end
	endgenerate

	// quad latch: a sampled latch costs one cycle of lag, but
	// keeps every output on a flip-flop; the value held after
	// the strobe falls is d of the last high cycle
	genvar l;
	generate
		for (l = 0; l < `TFL_LATCH_N; l = l + 1) begin : g_latch
			always @(posedge sys_clk) begin
				if (reset) begin
					lat_q_reg[l] <= `TFL_RST_Q;
					lat_qn_reg[l] <= `TFL_RST_QN;
				end else if (lat_strobe[l / `TFL_PAIR_SIZE]) begin
					lat_q_reg[l] <= lat_d[l];
					lat_qn_reg[l] <= ~lat_d[l];
				end
				// strobe low: hold last value
			end
		end
	endgenerate

	// outputs are each driven by one flip-flop only

endmodule

// ==== hw/tfl_jk_cell.v ====
/*
 * one master-slave j-k storage cell with sampled clock edges.
 * assumes a single system clock; the element clock is a
 * synchronous input, and direct inputs are active low.
 */
`include "tfl_defines.vh"

module tfl_jk_cell (
	input wire sys_clk,
	input wire reset,
	input wire clk_in,
	input wire j_in,
	input wire k_in,
	input wire set_n,
	input wire clr_n,
	output reg q_reg,
	output reg qn_reg
);

	reg clk_prev_reg;
	reg master_reg;
	reg master_lock_reg;
	reg slave_next;

	// slave next value; direct inputs win, else master on fall
	always @* begin
		slave_next = q_reg;
		if (!clr_n) begin
			slave_next = 1'h0; // clear wins when both low
		end else if (!set_n) begin
			slave_next = 1'h1;
		end else if (clk_prev_reg && !clk_in) begin
			slave_next = master_reg;
		end
	end

	// master captures once per high phase, slave on falling edge
	always @(posedge sys_clk) begin
		if (reset) begin
			clk_prev_reg <= `TFL_RST_HIST;
			master_reg <= `TFL_RST_Q;
			master_lock_reg <= `TFL_RST_HIST;
			q_reg <= `TFL_RST_Q;
			qn_reg <= `TFL_RST_QN;
		end else begin
			clk_prev_reg <= clk_in;
			q_reg <= slave_next;
			qn_reg <= ~slave_next;
			if (!clr_n) begin
				master_reg <= 1'h0;
				master_lock_reg <= clk_in;
			end else if (!set_n) begin
				master_reg <= 1'h1;
				master_lock_reg <= clk_in;
			end else if (!clk_in) begin
				// low phase: inputs ignored, master re-armed
				master_lock_reg <= 1'h0;
				master_reg <= q_reg;
			end else if (!master_lock_reg) begin
				// first high cycle takes the input once
				master_lock_reg <= 1'h1;
				case ({j_in, k_in})
				2'h0: master_reg <= q_reg;
				2'h1: master_reg <= 1'h0;
				2'h2: master_reg <= 1'h1;
				2'h3: master_reg <= ~q_reg;
				default: master_reg <= q_reg;
				endcase
			end
		end
	end

endmodule
